// File: hw/fmg_pkg.sv
// Constants for the flash modify guard and read power block
package fmg_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_REVISION  = 8'hE2;
  localparam logic [3:0] PAGE_REVISION  = 4'hF;
  localparam logic [7:0] ADDR_PS_CTRL   = 8'h8F;
  localparam logic [7:0] ADDR_FL_SCALE  = 8'hB6;
  localparam logic [7:0] ADDR_RST_CAUSE = 8'hEF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PS_WE_BIT      = 0;
  localparam int PS_EE_BIT      = 1;
  localparam int FL_BYPASS_BIT  = 6;
  localparam int RC_POWER_ON_RESET_FLAG_BIT   = 0;
  localparam int RC_MON_RST_BIT = 1;
  localparam int RC_FLASH_ERROR_FLAG_BIT  = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REVISION = 8'h00;
  localparam logic [7:0] RST_PS_CTRL  = 8'h00;
  localparam logic [7:0] RST_FL_SCALE = 8'h00;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int ROW_BYTES      = 64;
  localparam int ROW_SHIFT      = 6;
  localparam int CLK_MHZ        = 25;
  localparam int SENSE_PULSE_NS = 20;
  localparam int SENSE_CYCLES   = (SENSE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_MAX_CYC   = 3;
  localparam int FLASH_OP_CYC   = 8;

  typedef enum logic [2:0] {
    FMG_IDLE = 3'b001,
    FMG_BUSY = 3'b010,
    FMG_ERR  = 3'b100
  } fmg_state_t;

endpackage

// File: hw/fmg_row_reg.sv
// Open row register of the flash array
module fmg_row_reg #(
  parameter int AW = 16
) (
  // Clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_reset_n,
  // Read address
  input  wire logic          i_rd,
  input  wire logic [AW-1:0] i_addr,
  // Row status
  output logic               o_new_row
);

  logic [AW-1:fmg_pkg::ROW_SHIFT] row_reg;
  logic                           row_valid_reg;
  logic                           new_row_reg;
  wire                            row_diff;

  assign row_diff  = !row_valid_reg ||
                     (i_addr[AW-1:fmg_pkg::ROW_SHIFT] != row_reg);
  assign o_new_row = new_row_reg;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      row_reg       <= '0;
      row_valid_reg <= 1'b0;
      new_row_reg   <= 1'b0;
    end else begin
      new_row_reg <= i_rd && row_diff;
      if (i_rd) begin
        row_reg       <= i_addr[AW-1:fmg_pkg::ROW_SHIFT];
        row_valid_reg <= 1'b1;
      end
    end
  end

endmodule

// File: hw/fmg_top.sv
// Flash modify guard, sense-amp one-shot and revision register
module fmg_top #(
  parameter int AW = 16
) (
  // Clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_reset_n,
  input  wire logic          i_por,
  // Special function register port
  input  wire logic          i_sfr_wr,
  input  wire logic          i_sfr_rd,
  input  wire logic [3:0]    i_sfr_page,
  input  wire logic [7:0]    i_sfr_addr,
  input  wire logic [7:0]    i_sfr_wdata,
  output logic      [7:0]    o_sfr_rdata,
  // Supply monitor enable
  input  wire logic          i_mon_enable,
  // Flash access from the core
  input  wire logic          i_flash_rd,
  input  wire logic          i_movx_wr,
  input  wire logic [AW-1:0] i_flash_addr,
  // Interrupts and idle
  input  wire logic          i_irq,
  input  wire logic          i_idle,
  // Flash and system controls
  output logic               o_sense_en,
  output logic               o_new_row,
  output logic               o_flash_wr,
  output logic               o_flash_erase,
  output logic               o_flash_busy,
  output logic               o_irq_hold,
  output logic               o_irq_pend,
  output logic               o_wake,
  output logic               o_ferr_reset,
  output logic               o_mon_rst_en
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [7:0]           revision_reg;
  logic [7:0]           ps_ctrl_reg;
  logic [7:0]           fl_scale_reg;
  logic                 mon_rst_reg;
  logic                 power_on_reset_flag_reg;
  logic                 flash_error_flag_reg;
  logic [7:0]           rdata_reg;
  fmg_pkg::fmg_state_t  state_reg;
  logic [3:0]           op_cnt_reg;
  logic [3:0]           sense_cnt_reg;
  logic                 sense_reg;
  logic                 wr_reg;
  logic                 erase_reg;
  logic                 pend_reg;
  logic                 ferr_reg;
  logic                 wake_reg;
  logic                 ferr_hist_reg;
  logic                 rst_seen_reg;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  wire hit_rev   = (i_sfr_page == fmg_pkg::PAGE_REVISION) &&
                   (i_sfr_addr == fmg_pkg::ADDR_REVISION);
  wire hit_ps    = i_sfr_addr == fmg_pkg::ADDR_PS_CTRL;
  wire hit_fl    = i_sfr_addr == fmg_pkg::ADDR_FL_SCALE;
  wire hit_rc    = i_sfr_addr == fmg_pkg::ADDR_RST_CAUSE;
  wire we_bit    = ps_ctrl_reg[fmg_pkg::PS_WE_BIT];
  wire ee_bit    = ps_ctrl_reg[fmg_pkg::PS_EE_BIT];
  wire bypass    = fl_scale_reg[fmg_pkg::FL_BYPASS_BIT];
  wire idle_st   = state_reg == fmg_pkg::FMG_IDLE;
  // Monitor state taken in the very strobe cycle
  wire guard_ok  = i_mon_enable && mon_rst_reg;
  wire modify    = i_movx_wr && we_bit && idle_st;
  wire do_erase  = modify && ee_bit;
  wire bad_mod   = modify && !guard_ok;
  wire [7:0] rc_view = {1'b0, flash_error_flag_reg, 4'h0, mon_rst_reg, power_on_reset_flag_reg};
  wire [7:0] rd_mux  = hit_rev ? revision_reg :
                       hit_ps  ? {6'h00, ps_ctrl_reg[1:0]} :
                       hit_fl  ? fl_scale_reg :
                       hit_rc  ? rc_view : 8'h00;

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      revision_reg <= fmg_pkg::RST_REVISION;
      ps_ctrl_reg  <= fmg_pkg::RST_PS_CTRL;
      fl_scale_reg <= fmg_pkg::RST_FL_SCALE;
      rdata_reg    <= 8'h00;
    end else begin
      rdata_reg <= i_sfr_rd ? rd_mux : rdata_reg;
      if (i_sfr_wr && hit_rev) begin
        revision_reg <= i_sfr_wdata;
      end
      if (i_sfr_wr && hit_ps) begin
        ps_ctrl_reg <= {6'h00, i_sfr_wdata[1:0]};
      end
      if (i_sfr_wr && hit_fl) begin
        fl_scale_reg <= i_sfr_wdata;
      end
    end
  end

  // Reset cause bits take their reset values on i_reset_n, and are loaded
  // from i_por and the error mark on the first clock after any reset.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_seen_reg <= 1'b0;
      mon_rst_reg  <= 1'b1;
      power_on_reset_flag_reg    <= 1'b0;
      flash_error_flag_reg   <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b1;
      if (!rst_seen_reg) begin
        power_on_reset_flag_reg  <= i_por;
        flash_error_flag_reg <= !i_por && ferr_hist_reg;
      end else if (i_sfr_wr && hit_rc) begin
        // Direct assignment assumed from firmware
        mon_rst_reg <= i_sfr_wdata[fmg_pkg::RC_MON_RST_BIT];
        power_on_reset_flag_reg   <= i_sfr_wdata[fmg_pkg::RC_POWER_ON_RESET_FLAG_BIT];
      end
      if (i_por && !rst_seen_reg) begin
        mon_rst_reg <= 1'b1;
      end
    end
  end

  // No reset here: the error mark must outlive the reset it asks for.
  // Only a power-on reset clears it.
  always_ff @(posedge i_mclk) begin
    if (bad_mod) begin
      ferr_hist_reg <= 1'b1;
    end else if (i_por && !rst_seen_reg) begin
      ferr_hist_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Flash operation sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg  <= fmg_pkg::FMG_IDLE;
      op_cnt_reg <= 4'h0;
      wr_reg     <= 1'b0;
      erase_reg  <= 1'b0;
      ferr_reg   <= 1'b0;
    end else begin
      wr_reg    <= 1'b0;
      erase_reg <= 1'b0;
      case (state_reg)
        fmg_pkg::FMG_IDLE: begin
          if (bad_mod) begin
            state_reg <= fmg_pkg::FMG_ERR;
            ferr_reg  <= 1'b1;
          end else if (modify) begin
            state_reg  <= fmg_pkg::FMG_BUSY;
            op_cnt_reg <= 4'(fmg_pkg::FLASH_OP_CYC);
            wr_reg     <= !do_erase;
            erase_reg  <= do_erase;
          end
        end
        fmg_pkg::FMG_BUSY: begin
          op_cnt_reg <= op_cnt_reg - 4'h1;
          if (op_cnt_reg == 4'h1) begin
            state_reg <= fmg_pkg::FMG_IDLE;
          end
        end
        // Held until the reset this block requested arrives
        fmg_pkg::FMG_ERR: state_reg <= fmg_pkg::FMG_ERR;
        default: state_reg <= fmg_pkg::FMG_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Interrupt hold, idle wake, sense one-shot
  // ------------------------------------------------------------------
  // Busy bit of the one-hot state, so the busy outputs come from a flop
  wire busy = state_reg[1];

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_reg      <= 1'b0;
      wake_reg      <= 1'b0;
      sense_cnt_reg <= 4'h0;
      sense_reg     <= 1'b0;
    end else begin
      // Release at the end of the operation wins over a new request
      pend_reg <= (busy && i_irq) || (pend_reg && busy);
      // Registered wake lands one clock after the request
      wake_reg <= i_idle && i_irq && !busy;
      if (i_flash_rd && !bypass) begin
        sense_cnt_reg <= 4'(fmg_pkg::SENSE_CYCLES);
        sense_reg     <= 1'b1;
      end else if (sense_cnt_reg > 4'h1) begin
        sense_cnt_reg <= sense_cnt_reg - 4'h1;
      end else begin
        sense_cnt_reg <= 4'h0;
        sense_reg     <= bypass && i_flash_rd;
      end
    end
  end

  fmg_row_reg #(
    .AW (AW)
  ) u_row (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_rd      (i_flash_rd),
    .i_addr    (i_flash_addr),
    .o_new_row (o_new_row)
  );

  assign o_sfr_rdata   = rdata_reg;
  assign o_sense_en    = sense_reg;
  assign o_flash_wr    = wr_reg;
  assign o_flash_erase = erase_reg;
  assign o_flash_busy  = busy;
  assign o_irq_hold    = busy;
  assign o_irq_pend    = pend_reg;
  assign o_wake        = wake_reg;
  assign o_ferr_reset  = ferr_reg;
  assign o_mon_rst_en  = mon_rst_reg;

endmodule

// File: dv/fmg_core_model.sv
// Behavioural core model issuing flash fetches and MOVX writes
module fmg_core_model (
  // Clock
  input  wire logic        i_mclk,
  // Flash access towards the block
  output logic             o_flash_rd,
  output logic             o_movx_wr,
  output logic      [15:0] o_flash_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        rd_nxt = 1'b0;
  logic        wr_nxt = 1'b0;
  logic [15:0] ad_nxt = 16'h0000;
  initial begin
    o_flash_rd   = 1'b0;
    o_movx_wr    = 1'b0;
    o_flash_addr = 16'h0000;
  end
  // Idle address flips every cycle so a stale value never looks valid
  always @(negedge i_mclk) begin
    o_flash_rd   <= rd_nxt;
    o_movx_wr    <= wr_nxt;
    o_flash_addr <= (rd_nxt | wr_nxt) ? ad_nxt : ~o_flash_addr;
  end
  // One access cycle; returns once the block has sampled it
  task automatic access(input logic w, input logic [15:0] a);
    @(posedge i_mclk);
    ad_nxt = a;
    rd_nxt = !w;
    wr_nxt = w;
    @(posedge i_mclk);
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    @(negedge i_mclk);
  endtask
endmodule

// File: dv/fmg_top_asserts.sv
// Port checker for the flash modify guard top
module fmg_top_asserts (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Inputs
  input wire logic i_movx_wr,
  input wire logic i_mon_enable,
  input wire logic i_flash_rd,
  input wire logic i_irq,
  input wire logic i_idle,
  // Outputs
  input wire logic o_sense_en,
  input wire logic o_flash_wr,
  input wire logic o_flash_erase,
  input wire logic o_flash_busy,
  input wire logic o_irq_hold,
  input wire logic o_irq_pend,
  input wire logic o_wake,
  input wire logic o_ferr_reset,
  input wire logic o_mon_rst_en
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  AST_RST_MON: assert property (
    $rose(i_reset_n) |-> o_mon_rst_en)
    else $error("monitor reset role off after reset");
  AST_WR_SAFE: assert property (
    (o_flash_wr || o_flash_erase) |->
    $past(i_movx_wr) && $past(i_mon_enable) && $past(o_mon_rst_en))
    else $error("flash op started without guard");
  AST_ERR_CAUSE: assert property (
    $rose(o_ferr_reset) |->
    $past(i_movx_wr) && !($past(i_mon_enable) && $past(o_mon_rst_en)))
    else $error("error reset without unguarded write");
  AST_ERR_HOLD: assert property (
    o_ferr_reset |=> o_ferr_reset && !o_flash_wr && !o_flash_erase)
    else $error("error reset not held");
  AST_BUSY_LEN: assert property (
    $rose(o_flash_busy) |-> o_flash_busy [*8] ##1 !o_flash_busy)
    else $error("busy length wrong");
  AST_OP_BUSY: assert property (
    (o_flash_wr || o_flash_erase) |->
    $rose(o_flash_busy) && !(o_flash_wr && o_flash_erase))
    else $error("op pulse without busy start");
  AST_HOLD: assert property (
    o_irq_hold == o_flash_busy)
    else $error("irq hold differs from busy");
  AST_HOLD_SRC: assert property (
    $rose(o_irq_hold) |->
    $past(i_movx_wr) && $past(i_mon_enable) && $past(o_mon_rst_en))
    else $error("irq hold without guarded write");
  AST_PEND: assert property (
    i_irq && o_flash_busy ##1 o_flash_busy |-> o_irq_pend)
    else $error("irq not kept pending");
  AST_PEND_CLR: assert property (
    !o_flash_busy ##1 !o_flash_busy |-> !o_irq_pend)
    else $error("pending outside op");
  AST_SENSE: assert property (
    i_flash_rd |=> o_sense_en)
    else $error("no sense enable after read");
  AST_SENSE_SRC: assert property (
    o_sense_en |-> $past(i_flash_rd))
    else $error("sense enable without read");
  AST_WAKE: assert property (
    $rose(i_irq) && i_idle |-> ##[1:3] o_wake)
    else $error("wake too late");
endmodule

bind fmg_top fmg_top_asserts u_chk (.*);

// File: dv/fmg_top_tb_top.sv
// Self-checking bench for the flash modify guard top
module fmg_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Signals and helpers
  // ------------------------------------------------------------
  logic        i_mclk = 1'b0, i_reset_n = 1'b0, i_por = 1'b1, rd_d = 1'b0;
  logic        i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_mon_enable = 1'b1;
  logic        i_irq = 1'b0, i_idle = 1'b0, i_flash_rd, i_movx_wr;
  logic [3:0]  i_sfr_page = 4'h0;
  logic [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata;
  logic        o_sense_en, o_new_row, o_flash_wr, o_flash_erase, o_wake;
  logic        o_flash_busy, o_irq_hold, o_irq_pend, o_ferr_reset;
  logic        o_mon_rst_en;
  logic [15:0] i_flash_addr, a, prev, e;
  logic [31:0] seed = 32'h9bcf_a8be;
  logic [15:0] exq[$];
  int          bad_count = 0, checks = 0, cyc = 0;
  wire logic [9:0] flg = {o_mon_rst_en, o_irq_hold, o_sense_en, o_new_row,
    o_flash_wr, o_flash_erase, o_flash_busy, o_irq_pend, o_wake, o_ferr_reset};
  fmg_top #(.AW(16)) uut (.*);
  fmg_core_model core (.i_mclk(i_mclk), .o_flash_rd(i_flash_rd),
    .o_movx_wr(i_movx_wr), .o_flash_addr(i_flash_addr));
  initial forever #20 i_mclk = ~i_mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic fl(input logic [9:0] m, input logic [9:0] x);
    chk(flg & m, x);
  endtask
  task automatic rst(input logic p, input int n);
    i_por = p;
    i_reset_n = 1'b0;
    tick(n);
    i_reset_n = 1'b1;
    tick(2);
  endtask
  // Reads leave value and mask in the queue for the monitor
  task automatic sfr(input logic w, input logic [7:0] ad,
                     input logic [7:0] d, input logic [7:0] m);
    @(negedge i_mclk);
    i_sfr_wr = w;
    i_sfr_rd = !w;
    i_sfr_page = (ad == 8'he2) ? 4'hf : 4'h0;
    i_sfr_addr = ad;
    i_sfr_wdata = d;
    if (!w) exq.push_back({m, d});
    @(negedge i_mclk);
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
  endtask
  task automatic fetch(input logic [15:0] ad, input logic [9:0] x);
    core.access(1'b0, ad);
    fl(10'h0c0, x);
  endtask
  always @(posedge i_mclk) rd_d <= i_sfr_rd;
  always @(negedge i_mclk) begin
    cyc++;
    if (rd_d) begin
      e = exq.pop_front();
      chk({2'b00, o_sfr_rdata & e[15:8]}, {2'b00, e[7:0]});
    end
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst(1'b1, 12);
    fl(10'h3ff, 10'h200);
    sfr(1'b0, 8'hef, 8'h03, 8'h43);
    sfr(1'b0, 8'he2, 8'h00, 8'hff);
    sfr(1'b1, 8'he2, 8'ha5, 8'h00);
    sfr(1'b0, 8'he2, 8'ha5, 8'hff);
    sfr(1'b0, 8'h55, 8'h00, 8'hff);
    core.access(1'b0, 16'h0080);
    fetch(16'h0000, 10'h0c0);
    fetch(16'h003f, 10'h080);
    fetch(16'h0040, 10'h0c0);
    sfr(1'b1, 8'hb6, 8'h40, 8'h00);
    sfr(1'b0, 8'hb6, 8'h40, 8'h40);
    fetch(16'h0041, 10'h080);
    sfr(1'b1, 8'hb6, 8'h00, 8'h00);
    prev = 16'h0041;
    repeat (16) begin
      seed = lfsr(seed);
      a = {9'h000, seed[6:0]};
      fetch(a, {3'b001, a[15:6] != prev[15:6], 6'h00});
      prev = a;
    end
    // Upper control bits are written as junk and must read back zero
    sfr(1'b1, 8'h8f, 8'hfd, 8'h00);
    sfr(1'b0, 8'h8f, 8'h01, 8'hff);
    core.access(1'b1, 16'h0010);
    fl(10'h13d, 10'h128);
    i_irq = 1'b1;
    core.access(1'b1, 16'h0011);
    fl(10'h12c, 10'h10c);
    i_irq = 1'b0;
    tick(8);
    fl(10'h10c, 10'h000);
    sfr(1'b1, 8'h8f, 8'h03, 8'h00);
    core.access(1'b1, 16'h0020);
    fl(10'h030, 10'h010);
    tick(8);
    sfr(1'b1, 8'h8f, 8'h02, 8'h00);
    core.access(1'b1, 16'h0021);
    fl(10'h038, 10'h000);
    a = 16'h0000;
    i_idle = 1'b1;
    i_irq = 1'b1;
    repeat (3) begin
      tick(1);
      a[0] = a[0] | o_wake;
    end
    chk({9'h000, a[0]}, 10'h001);
    i_idle = 1'b0;
    i_irq = 1'b0;
    // Direct assignment with the power-on flag set drops the reset role
    sfr(1'b1, 8'hef, 8'h01, 8'h00);
    fl(10'h200, 10'h000);
    sfr(1'b1, 8'h8f, 8'h01, 8'h00);
    core.access(1'b1, 16'h0030);
    fl(10'h039, 10'h001);
    rst(1'b0, 2);
    sfr(1'b0, 8'hef, 8'h40, 8'h40);
    i_mon_enable = 1'b0;
    sfr(1'b1, 8'h8f, 8'h01, 8'h00);
    core.access(1'b1, 16'h0031);
    fl(10'h039, 10'h001);
    i_mon_enable = 1'b1;
    rst(1'b1, 2);
    fl(10'h201, 10'h200);
    final_report();
  end
endmodule
